// [core/plm_pkg.sv]
package plm_pkg;

    // Clock rate of the PHY logic clock.
    localparam int unsigned CLK_HZ          = 25000000;
    // Break-link wait before negotiation restarts, in milliseconds.
    localparam int unsigned BREAK_LINK_MS   = 1200;
    localparam longint unsigned BREAK_LINK_CYC =
        (longint'(BREAK_LINK_MS) * CLK_HZ) / 1000;

    // Control register 0 field positions.
    localparam int unsigned CTL_DUPLEX_BIT  = 8;
    localparam int unsigned CTL_RESTART_BIT = 9;
    localparam int unsigned CTL_ANEG_EN_BIT = 12;
    localparam int unsigned CTL_SPEED_BIT   = 13;

    // Expansion register 6 field positions.
    localparam int unsigned EXP_LP_ANEG_BIT = 0;
    localparam int unsigned EXP_PDF_BIT     = 4;
    localparam logic [15:0] EXP_RESET       = 16'h0000;

    // Partner ability register 5 layout.
    localparam int unsigned LPA_10HD_BIT    = 5;
    localparam int unsigned LPA_100HD_BIT   = 7;
    localparam logic [15:0] LPA_RESET       = 16'h0000;
    localparam logic [4:0]  LPA_SELECTOR    = 5'h01;

    // Crossover control register 27 bit 15 disables crossover.
    localparam int unsigned XOVR_DIS_BIT    = 15;

    // Transmit status word no-carrier bit.
    localparam int unsigned TXS_NOCARR_BIT  = 10;

    // Advertised ability field position in register 4.
    localparam int unsigned ADV_LO_BIT      = 5;

    typedef enum logic [1:0] {
        PLM_10HD,
        PLM_10FD,
        PLM_100HD,
        PLM_100FD
    } plm_mode_e;

    typedef enum {
        PLM_ST_IDLE,
        PLM_ST_BREAK,
        PLM_ST_NEG,
        PLM_ST_LINK
    } plm_state_e;

    // Line-side activity indications.
    typedef struct packed {
        logic flp_seen;
        logic mlt3_seen;
        logic nlp_seen;
        logic signal_ok;
        logic pd_fault;
    } plm_line_s;

    // Resolved operating mode.
    typedef struct packed {
        logic speed100;
        logic full_dup;
    } plm_oper_s;

endpackage : plm_pkg

// [core/plm_link_ctrl.sv]
`timescale 1ns/1ps
// Notes on behaviour
// - No FLPs: speed from symbols, half duplex.
// - Parallel-detected link clears register 6 bit 0.
// - Parallel detection fault sets register 6 bit 4.
// - Register 5 holds partner ability, speed.
// - Writing restart bit starts a new negotiation.
// - Loss of received signal restarts negotiation.
// - Restart halts traffic, waits break-link timer.
// - Negotiation off forces speed bit13, duplex bit8.
// - Forced bits ignored while negotiation enabled.
// - Half duplex: carrier on tx/rx, collision.
// - Full duplex: carrier on rx only, no collision.
// - Carrier low transmitting in full duplex, or in any mode when halted or link down.
// - Active carrier follows line activity.
// - Carrier drives transmit status no-carrier bit.
// - Crossover matches pairs to partner wiring.
// - Register 27.15 or pin disables crossover.
// - Crossover disabled: pair pin selects pairs.
// - Resolve highest common mode by priority.
// - Ability writes need restart to advertise.
module plm_link_ctrl #(
    parameter longint unsigned BREAK_CYC = plm_pkg::BREAK_LINK_CYC
) (
    input  wire logic              clock_i,
    input  wire logic              rst_n_i,
    input  wire logic [15:0]       ctrl_reg_i,
    input  wire logic              ctrl_wr_i,
    input  wire logic [3:0]        adv_ability_i,
    input  wire logic [3:0]        lp_ability_i,
    input  wire logic              lp_ability_vld_i,
    input  wire plm_pkg::plm_line_s line_i,
    input  wire logic              tx_active_i,
    input  wire logic              rx_active_i,
    input  wire logic              xovr_reg_i,
    input  wire logic              crossover_enable_pin,
    input  wire logic              pair_assignment_pin,
    input  wire logic              partner_swapped_i,
    output logic [15:0]            lp_ability_reg_o,
    output logic [15:0]            expansion_reg_o,
    output plm_pkg::plm_oper_s     oper_o,
    output logic                   link_up_o,
    output logic                   halt_o,
    output logic                   carrier_o,
    output logic                   collision_o,
    output logic                   tx_no_carrier_o,
    output logic                   pair_swap_o
);

    plm_pkg::plm_state_e state_r, state_nxt;
    logic [31:0]         cnt_r, cnt_nxt;
    logic [15:0]         lpa_r, lpa_nxt;
    logic [15:0]         exp_r, exp_nxt;
    plm_pkg::plm_oper_s  oper_r, oper_nxt;
    logic                link_r, link_nxt;
    logic                halt_r, halt_nxt;
    logic                crs_r, crs_nxt;
    logic                col_r, col_nxt;
    logic                nocar_r, nocar_nxt;
    logic                swap_r, swap_nxt;
    logic                rst_req;
    logic                aneg_en;
    logic [3:0]          common;

    assign rst_req = ctrl_wr_i && ctrl_reg_i[plm_pkg::CTL_RESTART_BIT];
    assign aneg_en = ctrl_reg_i[plm_pkg::CTL_ANEG_EN_BIT];
    assign common  = adv_ability_i & lp_ability_i;

    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        lpa_nxt   = lpa_r;
        exp_nxt   = exp_r;
        oper_nxt  = oper_r;
        link_nxt  = link_r;
        halt_nxt  = 1'b0;
        if (line_i.pd_fault && aneg_en && !line_i.flp_seen) begin
            exp_nxt[plm_pkg::EXP_PDF_BIT] = 1'b1;
        end
        if (lp_ability_vld_i) begin
            lpa_nxt = {7'h00, lp_ability_i, plm_pkg::LPA_SELECTOR};
        end
        if (!aneg_en) begin
            oper_nxt.speed100 = ctrl_reg_i[plm_pkg::CTL_SPEED_BIT];
            oper_nxt.full_dup = ctrl_reg_i[plm_pkg::CTL_DUPLEX_BIT];
            link_nxt  = line_i.signal_ok;
            state_nxt = plm_pkg::PLM_ST_IDLE;
        end else if (rst_req) begin
            state_nxt = plm_pkg::PLM_ST_BREAK;
            cnt_nxt   = 32'h0000_0000;
            link_nxt  = 1'b0;
            halt_nxt  = 1'b1;
        end else begin
            case (state_r)
                plm_pkg::PLM_ST_IDLE: begin
                    state_nxt = plm_pkg::PLM_ST_NEG;
                    link_nxt  = 1'b0;
                end
                plm_pkg::PLM_ST_BREAK: begin
                    halt_nxt = 1'b1;
                    cnt_nxt  = cnt_r + 32'h0000_0001;
                    if (cnt_r >= 32'(BREAK_CYC - 1)) begin
                        state_nxt = plm_pkg::PLM_ST_NEG;
                        halt_nxt  = 1'b0;
                    end
                end
                plm_pkg::PLM_ST_NEG: begin
                    if (line_i.flp_seen && lp_ability_vld_i) begin
                        state_nxt = plm_pkg::PLM_ST_LINK;
                        link_nxt  = 1'b1;
                        exp_nxt[plm_pkg::EXP_LP_ANEG_BIT] = 1'b1;
                        if (common[3]) begin
                            oper_nxt = '{speed100: 1'b1, full_dup: 1'b1};
                        end else if (common[2]) begin
                            oper_nxt = '{speed100: 1'b1, full_dup: 1'b0};
                        end else if (common[1]) begin
                            oper_nxt = '{speed100: 1'b0, full_dup: 1'b1};
                        end else if (common[0]) begin
                            oper_nxt = '{speed100: 1'b0, full_dup: 1'b0};
                        end else begin
                            state_nxt = plm_pkg::PLM_ST_NEG;
                            link_nxt  = 1'b0;
                        end
                    end else if (!line_i.flp_seen &&
                                 (line_i.mlt3_seen || line_i.nlp_seen)) begin
                        state_nxt = plm_pkg::PLM_ST_LINK;
                        link_nxt  = 1'b1;
                        oper_nxt.speed100 = line_i.mlt3_seen;
                        oper_nxt.full_dup = 1'b0;
                        exp_nxt[plm_pkg::EXP_LP_ANEG_BIT] = 1'b0;
                        lpa_nxt = plm_pkg::LPA_RESET;
                        lpa_nxt[4:0] = plm_pkg::LPA_SELECTOR;
                        if (line_i.mlt3_seen) begin
                            lpa_nxt[plm_pkg::LPA_100HD_BIT] = 1'b1;
                        end else begin
                            lpa_nxt[plm_pkg::LPA_10HD_BIT] = 1'b1;
                        end
                    end
                end
                plm_pkg::PLM_ST_LINK: begin
                    if (!line_i.signal_ok) begin
                        state_nxt = plm_pkg::PLM_ST_NEG;
                        link_nxt  = 1'b0;
                    end
                end
                default: begin
                    state_nxt = plm_pkg::PLM_ST_IDLE;
                end
            endcase
        end
    end

    always_comb begin
        if (oper_r.full_dup) begin
            crs_nxt = rx_active_i && !tx_active_i;
            col_nxt = 1'b0;
        end else begin
            crs_nxt = rx_active_i || tx_active_i;
            col_nxt = rx_active_i && tx_active_i;
        end
        if (halt_r || !link_r) begin
            crs_nxt = 1'b0;
            col_nxt = 1'b0;
        end
        nocar_nxt = tx_active_i && !crs_nxt;
        if (xovr_reg_i || !crossover_enable_pin) begin
            swap_nxt = pair_assignment_pin;
        end else if (!link_r) begin
            swap_nxt = partner_swapped_i;
        end else begin
            swap_nxt = swap_r;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_r <= plm_pkg::PLM_ST_IDLE;
            cnt_r   <= 32'h0000_0000;
            lpa_r   <= plm_pkg::LPA_RESET;
            exp_r   <= plm_pkg::EXP_RESET;
            oper_r  <= '{speed100: 1'b0, full_dup: 1'b0};
            link_r  <= 1'b0;
            halt_r  <= 1'b0;
            crs_r   <= 1'b0;
            col_r   <= 1'b0;
            nocar_r <= 1'b0;
            swap_r  <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            lpa_r   <= lpa_nxt;
            exp_r   <= exp_nxt;
            oper_r  <= oper_nxt;
            link_r  <= link_nxt;
            halt_r  <= halt_nxt;
            crs_r   <= crs_nxt;
            col_r   <= col_nxt;
            nocar_r <= nocar_nxt;
            swap_r  <= swap_nxt;
        end
    end

    assign lp_ability_reg_o = lpa_r;
    assign expansion_reg_o  = exp_r;
    assign oper_o           = oper_r;
    assign link_up_o        = link_r;
    assign halt_o           = halt_r;
    assign carrier_o        = crs_r;
    assign collision_o      = col_r;
    assign tx_no_carrier_o  = nocar_r;
    assign pair_swap_o      = swap_r;

endmodule : plm_link_ctrl

// [verif/plm_link_ctrl_monitor.sv]
`timescale 1ns/1ps
module plm_link_ctrl_monitor (
    input wire logic               clock_i,
    input wire logic               rst_n_i,
    input wire logic [15:0]        ctrl_reg_i,
    input wire logic               ctrl_wr_i,
    input wire plm_pkg::plm_line_s line_i,
    input wire logic               tx_active_i,
    input wire logic               rx_active_i,
    input wire logic               xovr_reg_i,
    input wire logic               crossover_enable_pin,
    input wire logic               pair_assignment_pin,
    input wire logic [15:0]        expansion_reg_o,
    input wire plm_pkg::plm_oper_s oper_o,
    input wire logic               link_up_o,
    input wire logic               halt_o,
    input wire logic               carrier_o,
    input wire logic               collision_o,
    input wire logic               tx_no_carrier_o,
    input wire logic               pair_swap_o
);
    wire req = ctrl_wr_i && ctrl_reg_i[9] && ctrl_reg_i[12];
    wire hd  = link_up_o && !halt_o && !oper_o.full_dup;
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    sequence hd_busy;
        hd && (tx_active_i || rx_active_i) ##1 hd;
    endsequence
    sequence fd_tx;
        oper_o.full_dup && tx_active_i ##1 oper_o.full_dup;
    endsequence
    restart_halt_a: assert property (req |=> halt_o && !link_up_o)
        else $error("restart did not halt");
    halt_once_a: assert property (!halt_o && !req |=> !halt_o)
        else $error("halt without restart");
    forced_mode_a: assert property (!ctrl_reg_i[12] ##1 !ctrl_reg_i[12]
        |-> oper_o == {$past(ctrl_reg_i[13]), $past(ctrl_reg_i[8])})
        else $error("forced mode wrong");
    fd_quiet_a: assert property (fd_tx |-> !carrier_o && !collision_o)
        else $error("full duplex carrier");
    hd_sense_a: assert property (hd_busy |-> carrier_o
        && collision_o == ($past(tx_active_i) && $past(rx_active_i)))
        else $error("half duplex carrier");
    no_carrier_a: assert property (tx_no_carrier_o ==
        ($past(tx_active_i) && !carrier_o))
        else $error("no carrier flag wrong");
    xovr_fixed_a: assert property (xovr_reg_i || !crossover_enable_pin
        |=> pair_swap_o == $past(pair_assignment_pin))
        else $error("pair select wrong");
    loss_drop_a: assert property (ctrl_reg_i[12] && !line_i.signal_ok
        |=> !link_up_o)
        else $error("link kept on loss");
    pd_link_a: assert property ($rose(link_up_o) && ctrl_reg_i[12]
        && !line_i.flp_seen |-> !oper_o.full_dup && !expansion_reg_o[0])
        else $error("parallel link wrong");
    pd_fault_a: assert property (ctrl_reg_i[12] && line_i.pd_fault
        && !line_i.flp_seen |=> expansion_reg_o[4])
        else $error("fault flag missing");
endmodule : plm_link_ctrl_monitor
bind plm_link_ctrl plm_link_ctrl_monitor mon_u (.*);

// [verif/plm_line_partner.sv]
`timescale 1ns/1ps
module plm_line_partner (
    input  wire logic          clock_i,
    input  wire logic [1:0]    kind_i,
    input  wire logic [3:0]    ability_i,
    input  wire logic          fault_i,
    output plm_pkg::plm_line_s line_o,
    output logic [3:0]         ability_o,
    output logic               valid_o
);
    always @(posedge clock_i) begin
        line_o <= '{kind_i == 2'h1, kind_i == 2'h2, kind_i == 2'h3,
                    kind_i != 2'h0, fault_i};
        valid_o <= kind_i == 2'h1;
        // A partner without pulse bursts drives the inverted ability word, with valid low.
        ability_o <= (kind_i == 2'h1) ? ability_i : ~ability_i;
    end
endmodule : plm_line_partner

// [verif/test_plm_link_ctrl.sv]
`timescale 1ns/1ps
module test_plm_link_ctrl;
    localparam int      BRK = 20;
    logic               clock_i = 1'b0;
    logic               rst_n_i = 1'b0;
    logic [15:0]        ctrl = 16'h1000;
    logic               wr = 1'b0, tx = 1'b0, rx = 1'b0, fault = 1'b0;
    logic               xreg = 1'b0, xen = 1'b1, psel = 1'b0, swp = 1'b0;
    logic [1:0]         kind = 2'h1;
    logic [3:0]         adv = 4'hf, lpab = 4'hf, pab;
    logic [15:0]        lpa, exr;
    logic               pvld, link, halt, crs, col, nocar, pswap, e;
    plm_pkg::plm_line_s line;
    plm_pkg::plm_oper_s oper;
    int                 error_cnt = 0, total_checks = 0, n, m;
    logic [3:0]         av[4] = '{4'h3, 4'hf, 4'hf, 4'hf};
    logic [3:0]         lv[4] = '{4'hf, 4'h4, 4'h2, 4'h1};
    logic [1:0]         ov[4] = '{2'h1, 2'h2, 2'h1, 2'h0};

    always #20 clock_i = ~clock_i;

    plm_line_partner partner_u (.clock_i(clock_i), .kind_i(kind),
        .ability_i(lpab), .fault_i(fault), .line_o(line),
        .ability_o(pab), .valid_o(pvld));
    plm_link_ctrl #(.BREAK_CYC(BRK)) dut_u (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .ctrl_reg_i(ctrl),
        .ctrl_wr_i(wr), .adv_ability_i(adv), .lp_ability_i(pab),
        .lp_ability_vld_i(pvld), .line_i(line), .tx_active_i(tx),
        .rx_active_i(rx), .xovr_reg_i(xreg),
        .crossover_enable_pin(xen), .pair_assignment_pin(psel),
        .partner_swapped_i(swp), .lp_ability_reg_o(lpa),
        .expansion_reg_o(exr), .oper_o(oper), .link_up_o(link),
        .halt_o(halt), .carrier_o(crs), .collision_o(col),
        .tx_no_carrier_o(nocar), .pair_swap_o(pswap));

    task tick;
        @(posedge clock_i);
        #1;
    endtask : tick
    task check(input string nm, input logic [15:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task end_of_test;
        if (error_cnt == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test
    task wait_link;
        for (n = 0; link !== 1'b1 && n < 60; n++)
            tick;
    endtask : wait_link
    task restart;
        ctrl[9] = 1'b1;
        wr = 1'b1;
        tick;
        wr = 1'b0;
        ctrl[9] = 1'b0;
        check("link", link, 0);
        for (n = 0; halt === 1'b1 && n < 99; n++)
            tick;
        check("break", n, BRK);
        wait_link;
    endtask : restart

    initial begin
        #100000;
        error_cnt++;
        end_of_test;
    end
    initial begin
        repeat (8) tick;
        rst_n_i = 1'b1;
        wait_link;
        check("oper", oper, 2'h3);
        check("lpa", lpa, 16'h01e1);
        check("nego", exr[0], 1);
        adv = 4'h3;
        ctrl = 16'h3100;
        repeat (4) tick;
        check("adv", oper, 2'h3);
        for (m = 0; m < 4; m++) begin
            adv = av[m];
            lpab = lv[m];
            restart;
            check("prio", oper, ov[m]);
        end
        kind = 2'h0;
        repeat (2) tick;
        check("loss", link, 0);
        kind = 2'h2;
        wait_link;
        check("pd100", {exr[0], oper, lpa[7]}, 4'h5);
        kind = 2'h0;
        repeat (2) tick;
        kind = 2'h3;
        fault = 1'b1;
        wait_link;
        check("pd10", {exr[4], oper, lpa[5]}, 4'h9);
        fault = 1'b0;
        ctrl = 16'h0200;
        wr = 1'b1;
        tick;
        wr = 1'b0;
        tick;
        check("refuse", halt, 0);
        for (m = 0; m < 16; m++) begin
            ctrl[13] = m[3];
            ctrl[8] = m[2];
            tx = m[1];
            rx = m[0];
            repeat (2) tick;
            e = m[2] ? rx & !tx : rx | tx;
            check("forced", oper, m[3:2]);
            check("crs", crs, e);
            check("col", col, !m[2] & tx & rx);
            if (!m[2])
                check("nocar", nocar, tx & !e);
        end
        tx = 1'b0;
        rx = 1'b0;
        for (m = 0; m < 4; m++) begin
            xreg = m[0];
            xen = m[0];
            psel = m[1];
            swp = !m[1];
            repeat (2) tick;
            check("pair", pswap, m[1]);
        end
        xreg = 1'b0;
        xen = 1'b1;
        kind = 2'h0;
        swp = 1'b0;
        tx = 1'b1;
        repeat (3) tick;
        check("auto", pswap, 0);
        check("crs_down", crs, 0);
        check("nocar_down", nocar, 1);
        tx = 1'b0;
        kind = 2'h3;
        repeat (3) tick;
        swp = 1'b1;
        repeat (2) tick;
        check("hold", pswap, 0);
        end_of_test;
    end
endmodule : test_plm_link_ctrl
